// ---- i2c_slave_pkg.sv ----
/*
 * Shared constants for the two-wire slave block: register offsets,
 * field positions, reset values, link states and build options.
 * Assumes a 32-bit APB master and a 100 MHz system clock.
 */
// What this block does
// - data and clock pins are open-drain, pulled up outside; no select line
// - slave only: slave-transmit and slave-receive; the external master owns the bus
// - build option picks serial or segment pins; unselected means enable ignored
// - build option debounces incoming bus lines by none, one or two clocks
// - build option lets the interface keep running without internal clock gating
// - all data bytes pass through the one shared data register; the address byte does not
// - idle-run bit 4 of clock mode register keeps or stops work in Idle
// - enable low floats both lines and frees pins for segments
// - mode bits pattern 110 selects two-wire slave operation
// - transmit: ninth-clock acknowledge clears receive-ack flag; high stops sending
// - eighth bit after address is captured into slave read/write flag
// - receive: transmit-ack bit is driven on the ninth clock
// - direction bit high means transmit, low means receive
// - bus-busy flag set on START, cleared on STOP
// - address-match flag high on match, low otherwise
// - transfer-complete flag zero while shifting, high after byte, raises interrupt
// - slave address sits in bits 7 to 1; bit 0 unused
// - address received MSB first; match sets flag and raises interrupt
// - START is data falling while clock stays high
// - on match, data driven low during the ninth bit
// - after receive-mode match, a dummy data read releases the held clock
// - bytes are eight bits, MSB first, both directions
`default_nettype none
package i2c_slave_pkg;
   // ===================================================
   // register offsets (byte addresses)
   localparam logic [7:0] OFF_MODCTL = 8'h00;
   localparam logic [7:0] OFF_STAT = 8'h04;
   localparam logic [7:0] OFF_ADDR = 8'h08;
   localparam logic [7:0] OFF_DATA = 8'h0c;
   localparam logic [7:0] OFF_CLOCK_MODE_REGISTER = 8'h10;
   // ===================================================
   // field positions
   localparam int EN_BIT = 1;
   localparam int MODE_LSB = 5;
   localparam logic [2:0] MODE_TWO_WIRE = 3'h6;
   localparam int IDLE_RUN_BIT = 4;
   localparam int ST_DONE = 7;
   localparam int ST_MATCH = 6;
   localparam int ST_BUSY = 5;
   localparam int ST_DIR = 4;
   localparam int ST_TRANSMIT_ACK_BIT = 3;
   localparam int ST_SRW = 2;
   localparam int ST_RECEIVE_ACK_FLAG = 0;
   // ===================================================
   // reset values and counts
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] ACK_SLOT = 4'h9;
   localparam int DEBOUNCE_NONE = 0;
   localparam int DEBOUNCE_ONE = 1;
   localparam int DEBOUNCE_TWO = 2;
   // ===================================================
   // link states
   typedef enum logic [8:0] {
      S_IDLE = 9'h001,
      S_ADDR = 9'h002,
      S_AACK = 9'h004,
      S_HOLD = 9'h008,
      S_TX = 9'h010,
      S_TXACK = 9'h020,
      S_RX = 9'h040,
      S_RXACK = 9'h080,
      S_SKIP = 9'h100
   } link_state_e;
endpackage
`default_nettype wire

// ---- line_filter.sv ----
/*
 * Two-flop synchroniser plus debounce for one incoming bus line.
 * Assumes the line is asynchronous to clk_in and idles high.
 */
`default_nettype none
module line_filter #(
   parameter int DEBOUNCE = 0
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_n_in,
   // line
   input wire logic line_in,
   output logic line_out
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic q;
      logic [1:0] cnt;
   } filt_s;
   localparam logic [1:0] LIMIT = 2'(DEBOUNCE);
   filt_s r;
   filt_s next_r;

   // ===================================================
   // new level accepted only after it stayed put LIMIT clocks
   always_comb begin
      next_r = r;
      next_r.s1 = line_in;
      next_r.s2 = r.s1;
      if (r.s2 == r.q) begin
         next_r.cnt = 2'h0;
      end else if (r.cnt == LIMIT) begin
         next_r.q = r.s2;
         next_r.cnt = 2'h0;
      end else begin
         next_r.cnt = r.cnt + 2'h1;
      end
   end

   // lines idle high behind pull-ups
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         r <= '{1'b1, 1'b1, 1'b1, 2'h0};
      end else begin
         r <= next_r;
      end
   end

   assign line_out = r.q;
endmodule
`default_nettype wire

// ---- bus_events.sv ----
/*
 * Finds clock edges and START/STOP conditions on filtered lines.
 * Assumes both inputs are already synchronised to clk_in.
 */
`default_nettype none
module bus_events (
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_n_in,
   // filtered lines
   input wire logic scl_in,
   input wire logic sda_in,
   // one-cycle events
   output logic start_out,
   output logic stop_out,
   output logic rise_out,
   output logic fall_out
);
   typedef struct packed {
      logic scl;
      logic sda;
   } prev_s;
   prev_s r;
   prev_s next_r;

   // ===================================================
   always_comb begin
      next_r.scl = scl_in;
      next_r.sda = sda_in;
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         r <= '{1'b1, 1'b1};
      end else begin
         r <= next_r;
      end
   end

   // data moving while clock stays high marks framing
   assign start_out = scl_in & r.scl & r.sda & ~sda_in;
   assign stop_out = scl_in & r.scl & ~r.sda & sda_in;
   assign rise_out = scl_in & ~r.scl;
   assign fall_out = ~scl_in & r.scl;
endmodule
`default_nettype wire

// ---- i2c_slave_interface.sv ----
/*
 * Two-wire slave interface with APB register access: START/STOP
 * detection, address match, byte shifting, acknowledge and clock
 * stretching. Assumes an APB master on CLK_SYS_IN and an external
 * bus master with pull-ups on both lines.
 */
// The register addresses and the APB slave port were chosen for this implementation.
`default_nettype none
module i2c_slave_interface #(
   parameter bit SERIAL_FUNC_SEL = 1'b1,
   parameter bit CLOCKLESS_RUN = 1'b0,
   parameter int DEBOUNCE = i2c_slave_pkg::DEBOUNCE_NONE
) (
   // clock and reset
   input wire logic CLK_SYS_IN,
   input wire logic RESET_N_IN,
   // apb slave
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [7:0] PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   output logic [31:0] PRDATA_OUT,
   output logic PREADY_OUT,
   output logic PSLVERR_OUT,
   // power manager
   input wire logic IDLE_MODE_IN,
   // two-wire pins, open drain
   input wire logic SCL_IN,
   output logic SCL_OUT,
   output logic SCL_OE_OUT,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE_OUT,
   // system side
   output logic SEG_SEL_OUT,
   output logic IRQ_OUT
);
   localparam logic [2:0] SEL_MODCTL = 3'h0;
   localparam logic [2:0] SEL_STAT = 3'h1;
   localparam logic [2:0] SEL_ADDR = 3'h2;
   localparam logic [2:0] SEL_DATA = 3'h3;
   localparam logic [2:0] SEL_CLOCK_MODE_REGISTER = 3'h4;
   localparam logic [2:0] SEL_NONE = 3'h7;

   typedef struct packed {
      i2c_slave_pkg::link_state_e st;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [7:0] data;
      logic [7:0] addr;
      logic [7:0] ctl;
      logic [7:0] clock_mode_register;
      logic dir;
      logic transmit_ack_bit;
      logic slave_read_write_flag;
      logic receive_ack_flag;
      logic busy;
      logic match;
      logic done;
      logic sda_oe;
      logic scl_oe;
      logic low;
      logic segment_pin;
      logic irq;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } top_s;

   top_s r;
   top_s next_r;
   logic [1:0] raw;
   logic [1:0] filt;
   logic scl_f;
   logic sda_f;
   logic ev_start;
   logic ev_stop;
   logic ev_rise;
   logic ev_fall;
   logic en;
   logic run;
   logic step;
   logic acc;
   logic wr;
   logic rd;
   logic touch;
   logic [2:0] sel;
   logic [7:0] wd;
   logic [7:0] rmux;
   logic [7:0] got;
   logic hit;

   // ===================================================
   // address decode, shared by read mux and write path
   function automatic logic [2:0] reg_sel(input logic [7:0] a);
      case (a)
         i2c_slave_pkg::OFF_MODCTL: reg_sel = SEL_MODCTL;
         i2c_slave_pkg::OFF_STAT: reg_sel = SEL_STAT;
         i2c_slave_pkg::OFF_ADDR: reg_sel = SEL_ADDR;
         i2c_slave_pkg::OFF_DATA: reg_sel = SEL_DATA;
         i2c_slave_pkg::OFF_CLOCK_MODE_REGISTER: reg_sel = SEL_CLOCK_MODE_REGISTER;
         default: reg_sel = SEL_NONE;
      endcase
   endfunction

   // ===================================================
   // line conditioning, one filter per line
   assign raw = {SDA_IN, SCL_IN};
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_line
         line_filter #(.DEBOUNCE(DEBOUNCE)) u_filt (
            .clk_in(CLK_SYS_IN),
            .reset_n_in(RESET_N_IN),
            .line_in(raw[gi]),
            .line_out(filt[gi])
         );
      end
   endgenerate
   assign scl_f = filt[0];
   assign sda_f = filt[1];

   bus_events u_events (
      .clk_in(CLK_SYS_IN),
      .reset_n_in(RESET_N_IN),
      .scl_in(scl_f),
      .sda_in(sda_f),
      .start_out(ev_start),
      .stop_out(ev_stop),
      .rise_out(ev_rise),
      .fall_out(ev_fall)
   );

   // ===================================================
   // enables: build option, enable bit, mode bits, idle gating
   assign en = SERIAL_FUNC_SEL & r.ctl[i2c_slave_pkg::EN_BIT]
      & (r.ctl[7:i2c_slave_pkg::MODE_LSB]
      == i2c_slave_pkg::MODE_TWO_WIRE);
   assign run = CLOCKLESS_RUN | ~IDLE_MODE_IN
      | r.clock_mode_register[i2c_slave_pkg::IDLE_RUN_BIT];
   assign step = en & run & ~ev_start & ~ev_stop;

   // apb strobes; one wait state before pready
   assign acc = PSEL_IN & PENABLE_IN;
   assign sel = reg_sel(PADDR_IN);
   assign wr = acc & r.pready & PWRITE_IN;
   assign rd = acc & r.pready & ~PWRITE_IN;
   assign touch = (wr | rd) & (sel == SEL_DATA);
   assign wd = PWDATA_IN[7:0];
   assign got = {r.sh[6:0], sda_f};
   assign hit = (got[7:1] == r.addr[7:1]);

   // read mux; status bit 1 and unmapped offsets read zero, other unused bits read back as written
   always_comb begin
      case (sel)
         SEL_MODCTL: rmux = r.ctl;
         SEL_STAT: rmux = {r.done, r.match, r.busy, r.dir,
            r.transmit_ack_bit, r.slave_read_write_flag, 1'b0, r.receive_ack_flag};
         SEL_ADDR: rmux = r.addr;
         SEL_DATA: rmux = r.data;
         SEL_CLOCK_MODE_REGISTER: rmux = r.clock_mode_register;
         default: rmux = 8'h00;
      endcase
   end

   // ===================================================
   // register and link next state
   always_comb begin
      next_r = r;
      next_r.irq = 1'b0;
      next_r.low = 1'b0;
      next_r.pready = acc & ~r.pready;
      next_r.pslverr = acc & ~r.pready & (sel == SEL_NONE);
      if (acc & ~r.pready) begin
         next_r.prdata = {24'h000000, rmux};
      end
      if (wr) begin
         case (sel)
            SEL_MODCTL: next_r.ctl = wd;
            SEL_STAT: begin
               next_r.dir = wd[i2c_slave_pkg::ST_DIR];
               next_r.transmit_ack_bit = wd[i2c_slave_pkg::ST_TRANSMIT_ACK_BIT];
            end
            SEL_ADDR: next_r.addr = wd;
            SEL_DATA: begin
               // shifter owns the byte while sending
               if (r.st != i2c_slave_pkg::S_TX) begin
                  next_r.data = wd;
               end
            end
            SEL_CLOCK_MODE_REGISTER: next_r.clock_mode_register = wd;
            default: next_r.ctl = r.ctl;
         endcase
      end
      next_r.segment_pin = ~(SERIAL_FUNC_SEL & r.ctl[i2c_slave_pkg::EN_BIT]);
      if (!en) begin
         // disabled: float both lines, forget the frame
         next_r.st = i2c_slave_pkg::S_IDLE;
         next_r.sda_oe = 1'b0;
         next_r.scl_oe = 1'b0;
         next_r.busy = 1'b0;
         next_r.match = 1'b0;
         next_r.cnt = 4'h0;
      end else if (!run) begin
         // stopped in Idle: the link holds; APB register access still goes on
         next_r.st = r.st;
      end else if (ev_start) begin
         next_r.busy = 1'b1;
         next_r.match = 1'b0;
         next_r.st = i2c_slave_pkg::S_ADDR;
         next_r.cnt = 4'h0;
         next_r.sda_oe = 1'b0;
         next_r.scl_oe = 1'b0;
      end else if (ev_stop) begin
         next_r.busy = 1'b0;
         next_r.st = i2c_slave_pkg::S_IDLE;
         next_r.sda_oe = 1'b0;
         next_r.scl_oe = 1'b0;
      end else begin
         case (r.st)
            i2c_slave_pkg::S_IDLE: next_r.st = r.st;
            i2c_slave_pkg::S_ADDR: begin
               if (ev_rise) begin
                  // address MSB first, then the read/write bit
                  next_r.sh = got;
                  next_r.cnt = r.cnt + 4'h1;
                  if (r.cnt == i2c_slave_pkg::BYTE_BITS - 4'h1) begin
                     next_r.cnt = 4'h0;
                     if (hit) begin
                        next_r.slave_read_write_flag = sda_f;
                        next_r.match = 1'b1;
                        next_r.irq = 1'b1;
                        next_r.st = i2c_slave_pkg::S_AACK;
                     end else begin
                        next_r.match = 1'b0;
                        next_r.st = i2c_slave_pkg::S_SKIP;
                     end
                  end
               end
            end
            i2c_slave_pkg::S_AACK: begin
               // first fall: pull data low; second: stretch clock
               if (ev_fall) begin
                  if (!r.sda_oe) begin
                     next_r.sda_oe = 1'b1;
                  end else begin
                     next_r.sda_oe = 1'b0;
                     next_r.scl_oe = 1'b1;
                     next_r.st = i2c_slave_pkg::S_HOLD;
                  end
               end
            end
            i2c_slave_pkg::S_HOLD: begin
               // any data register access lets the clock go
               if (touch) begin
                  next_r.scl_oe = 1'b0;
                  next_r.match = 1'b0;
                  next_r.done = 1'b0;
                  next_r.cnt = 4'h0;
                  if (r.dir) begin
                     next_r.sh = wr ? wd : r.data;
                     next_r.sda_oe = wr ? ~wd[7] : ~r.data[7];
                     next_r.st = i2c_slave_pkg::S_TX;
                  end else begin
                     next_r.st = i2c_slave_pkg::S_RX;
                  end
               end
            end
            i2c_slave_pkg::S_TX: begin
               if (ev_rise) begin
                  next_r.cnt = r.cnt + 4'h1;
               end
               if (ev_fall) begin
                  if (r.cnt == i2c_slave_pkg::BYTE_BITS) begin
                     next_r.sda_oe = 1'b0;
                     next_r.st = i2c_slave_pkg::S_TXACK;
                  end else begin
                     next_r.sh = {r.sh[6:0], 1'b0};
                     next_r.sda_oe = ~r.sh[6];
                  end
               end
            end
            i2c_slave_pkg::S_TXACK: begin
               if (ev_rise) begin
                  next_r.receive_ack_flag = sda_f;
                  next_r.done = 1'b1;
                  next_r.irq = 1'b1;
                  next_r.cnt = i2c_slave_pkg::ACK_SLOT;
                  if (sda_f) begin
                     // no acknowledge: stop sending, await STOP
                     next_r.st = i2c_slave_pkg::S_SKIP;
                  end
               end
               if (ev_fall && r.cnt == i2c_slave_pkg::ACK_SLOT) begin
                  next_r.scl_oe = 1'b1;
                  next_r.st = i2c_slave_pkg::S_HOLD;
               end
            end
            i2c_slave_pkg::S_RX: begin
               if (ev_rise) begin
                  next_r.sh = got;
                  next_r.cnt = r.cnt + 4'h1;
                  if (r.cnt == i2c_slave_pkg::BYTE_BITS - 4'h1) begin
                     next_r.data = got;
                     next_r.done = 1'b1;
                     next_r.irq = 1'b1;
                  end
               end
               if (ev_fall && r.cnt == i2c_slave_pkg::BYTE_BITS) begin
                  next_r.sda_oe = ~r.transmit_ack_bit;
                  next_r.st = i2c_slave_pkg::S_RXACK;
               end
            end
            i2c_slave_pkg::S_RXACK: begin
               if (ev_fall) begin
                  next_r.sda_oe = 1'b0;
                  if (r.transmit_ack_bit) begin
                     next_r.st = i2c_slave_pkg::S_SKIP;
                  end else begin
                     next_r.scl_oe = 1'b1;
                     next_r.st = i2c_slave_pkg::S_HOLD;
                  end
               end
            end
            i2c_slave_pkg::S_SKIP: next_r.st = r.st;
            default: next_r.st = i2c_slave_pkg::S_IDLE;
         endcase
      end
   end

   // ===================================================
   // state register
   always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         r <= '0;
         r.st <= i2c_slave_pkg::S_IDLE;
         r.ctl <= i2c_slave_pkg::RST_REG;
         r.addr <= i2c_slave_pkg::RST_REG;
         r.clock_mode_register <= i2c_slave_pkg::RST_REG;
         r.data <= i2c_slave_pkg::RST_REG;
         r.segment_pin <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   // outputs straight from the state register
   assign PRDATA_OUT = r.prdata;
   assign PREADY_OUT = r.pready;
   assign PSLVERR_OUT = r.pslverr;
   assign SDA_OUT = r.low;
   assign SCL_OUT = r.low;
   assign SDA_OE_OUT = r.sda_oe;
   assign SCL_OE_OUT = r.scl_oe;
   assign SEG_SEL_OUT = r.segment_pin;
   assign IRQ_OUT = r.irq;

   // ===================================================
   // assertions
   default clocking cb @(posedge CLK_SYS_IN); endclocking
   default disable iff (!RESET_N_IN);

   property p_open_drain;
      SDA_OUT == 1'b0 && SCL_OUT == 1'b0;
   endproperty
   a_open_drain: assert property (p_open_drain)
      else $error("pin driven high");

   property p_disabled_float;
      !en |=> !SDA_OE_OUT && !SCL_OE_OUT ##1 !en || !SDA_OE_OUT;
   endproperty
   a_disabled_float: assert property (p_disabled_float)
      else $error("pin pulled while disabled");

   property p_busy;
      en && run && ev_start |=> r.busy ##0 r.st == i2c_slave_pkg::S_ADDR;
   endproperty
   a_busy: assert property (p_busy)
      else $error("busy not set on start");

   property p_free;
      en && run && ev_stop && !ev_start |=> !r.busy && !SCL_OE_OUT;
   endproperty
   a_free: assert property (p_free)
      else $error("busy not cleared on stop");

   property p_match;
      step && r.st == i2c_slave_pkg::S_ADDR && ev_rise
         && r.cnt == 4'h7 && hit
         |=> r.match && IRQ_OUT && r.slave_read_write_flag == $past(sda_f)
         ##1 !IRQ_OUT;
   endproperty
   a_match: assert property (p_match)
      else $error("address match not flagged");

   property p_mismatch;
      step && r.st == i2c_slave_pkg::S_ADDR && ev_rise
         && r.cnt == 4'h7 && !hit
         |=> !r.match && !IRQ_OUT && !SDA_OE_OUT
         && r.st == i2c_slave_pkg::S_SKIP;
   endproperty
   a_mismatch: assert property (p_mismatch)
      else $error("foreign address answered");

   property p_hold;
      step && r.st == i2c_slave_pkg::S_HOLD && !touch
         |=> SCL_OE_OUT;
   endproperty
   a_hold: assert property (p_hold)
      else $error("clock released without data access");

   property p_receive_ack_flag;
      step && r.st == i2c_slave_pkg::S_TXACK && ev_rise
         |=> r.receive_ack_flag == $past(sda_f) && r.done && IRQ_OUT;
   endproperty
   a_receive_ack_flag: assert property (p_receive_ack_flag)
      else $error("receive ack not captured");

   property p_transmit_ack_bit;
      step && r.st == i2c_slave_pkg::S_RX && ev_fall
         && r.cnt == 4'h8 |=> SDA_OE_OUT == !$past(r.transmit_ack_bit);
   endproperty
   a_transmit_ack_bit: assert property (p_transmit_ack_bit)
      else $error("transmit ack not driven");

   property p_done_clear;
      step && r.st == i2c_slave_pkg::S_HOLD && touch
         |=> !r.done && !SCL_OE_OUT;
   endproperty
   a_done_clear: assert property (p_done_clear)
      else $error("complete flag kept while shifting");

   c_match: cover property (step && r.st == i2c_slave_pkg::S_AACK);
   c_tx_done: cover property (r.st == i2c_slave_pkg::S_TXACK && r.done);
   c_rx_done: cover property (r.st == i2c_slave_pkg::S_RXACK);
   c_stop: cover property (en && ev_stop && r.busy);
endmodule
`default_nettype wire

// ---- bus_master_model.sv ----
/* two-wire bus master model, 80 ns bits, honours stretching
   assumes the bench resolves both open-drain lines with pull-ups */
`default_nettype none
module bus_master_model (
   // resolved lines
   input wire logic scl_in,
   input wire logic sda_in,
   // pull-downs, high pulls the line low
   output logic scl_low_out = 1'b0,
   output logic sda_low_out = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;
   int stuck = 0;
   // ===================================================
   // release clock, bounded wait while the slave stretches it
   task automatic wait_high();
      int n = 0;
      scl_low_out = 1'b0;
      while (scl_in !== 1'b1 && n < 5000) begin
         #10 n++;
      end
      if (n >= 5000) stuck++;
   endtask
   // data set while clock low, sampled while high
   task automatic bit_io(input logic b, output logic r);
      sda_low_out = !b;
      #30 wait_high();
      #30 r = sda_in;
      scl_low_out = 1'b1;
      #20;
   endtask
   task automatic xfer(input logic [7:0] d, input logic m,
         output logic [7:0] q, output logic ak);
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(m, ak);
   endtask
   task automatic start();
      sda_low_out = 1'b0;
      wait_high();
      #40 sda_low_out = 1'b1;
      #40 scl_low_out = 1'b1;
   endtask
   task automatic stop();
      sda_low_out = 1'b1;
      #30 wait_high();
      #40 sda_low_out = 1'b0;
      #40;
   endtask
endmodule
`default_nettype wire

// ---- i2c_slave_interface_test.sv ----
/* self-checking bench: apb register tasks and random bus frames
   assumes the package, design and bus master model compiled first */
`default_nettype none
module i2c_slave_interface_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, idle = 0;
   logic [7:0] paddr = 0, q, got;
   logic [31:0] pwdata = 0;
   logic [6:0] sa;
   logic e, ak;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, scl_oe, sda_oe, segment_pin, irq, m_scl, m_sda;
   // wired-and with pull-ups
   wire logic scl = !(scl_oe || m_scl);
   wire logic sda = !(sda_oe || m_sda);
   int n_fail = 0, check_count = 0, seed = 28513, irqs = 0;
   localparam logic [7:0] STAT = i2c_slave_pkg::OFF_STAT;
   localparam logic [7:0] DATA = i2c_slave_pkg::OFF_DATA;
   always #5 clk = ~clk;
   // count interrupt pulses
   always @(posedge clk) if (irq === 1'b1) irqs++;
   i2c_slave_interface u_i2c_slave_interface (.CLK_SYS_IN(clk),
      .RESET_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen),
      .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
      .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
      .IDLE_MODE_IN(idle), .SCL_IN(scl), .SCL_OUT(), .SCL_OE_OUT(scl_oe),
      .SDA_IN(sda), .SDA_OUT(), .SDA_OE_OUT(sda_oe), .SEG_SEL_OUT(segment_pin),
      .IRQ_OUT(irq));
   bus_master_model u_bus_master_model (.scl_in(scl), .sda_in(sda),
      .scl_low_out(m_scl), .sda_low_out(m_sda));
   // ===================================================
   function automatic logic [7:0] flags(logic m, logic b, logic rw);
      return (8'(m) << i2c_slave_pkg::ST_MATCH) |
         (8'(b) << i2c_slave_pkg::ST_BUSY) | (8'(rw) << i2c_slave_pkg::ST_SRW);
   endfunction
   task automatic chk(input logic [7:0] g, input logic [7:0] x);
      check_count++;
      if (g !== x) begin
         n_fail++;
         $display("BAD %0t got %h want %h", $time, g, x);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // one apb transfer; wait for ready is bounded
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n = 0;
      @(posedge clk);
      psel <= 1;
      pwr <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      pen <= 1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 100);
      q = prdata[7:0];
      e = pslverr;
      psel <= 0;
      pen <= 0;
      if (n >= 100) begin
         n_fail++;
         summarize();
      end
   endtask
   // one frame: address, one byte either way when matched, stop
   task automatic frame(input logic rw, input logic miss);
      logic [7:0] d;
      int k;
      d = 8'($random(seed));
      k = irqs;
      u_bus_master_model.start();
      u_bus_master_model.xfer({sa ^ 7'(miss), rw}, 1'b1, got, ak);
      chk({7'h0, ak}, {7'h0, miss});
      chk(8'(irqs - k), {7'h0, !miss});
      if (!miss) begin
         apb(0, STAT, 0);
         chk(q & flags(1, 1, 1), flags(1, 1, rw));
         if (rw) begin
            fork
               u_bus_master_model.xfer(8'hff, 1'b1, got, ak);
               begin
                  apb(1, STAT, 8'h10);
                  apb(1, DATA, d);
               end
            join
            chk(got, d);
            apb(0, STAT, 0);
            chk(q & 8'h81, 8'h81);
         end else begin
            fork
               u_bus_master_model.xfer(d, 1'b1, got, ak);
               apb(0, DATA, 0);
            join
            chk({7'h0, ak}, 8'h00);
            apb(0, STAT, 0);
            chk(q & 8'h80, 8'h80);
         end
      end
      fork
         u_bus_master_model.stop();
         if (!miss && !rw) apb(0, DATA, 0);
      join
      if (!miss && !rw) chk(q, d);
      apb(0, STAT, 0);
      chk(q & flags(0, 1, 0), 8'h00);
      apb(1, STAT, 8'h00);
      chk(8'(u_bus_master_model.stuck), 8'h00);
      $display("frame rw %0d miss %0d done", rw, miss);
   endtask
   // main sequence, then a guard against hangs
   initial begin
      repeat (20) @(posedge clk);
      chk({7'h0, segment_pin}, 8'h01);
      rst_n <= 1;
      apb(0, STAT, 0);
      chk(q, i2c_slave_pkg::RST_REG);
      apb(0, 8'h14, 0);
      chk({7'h0, e}, 8'h01);
      sa = 7'($random(seed));
      apb(1, i2c_slave_pkg::OFF_ADDR, {sa, 1'b0});
      apb(1, i2c_slave_pkg::OFF_MODCTL, {i2c_slave_pkg::MODE_TWO_WIRE, 5'h02});
      apb(1, STAT, 8'h00);
      chk({7'h0, segment_pin}, 8'h00);
      apb(1, i2c_slave_pkg::OFF_CLOCK_MODE_REGISTER, 8'h10);
      // later frames run in Idle, kept alive by the idle-run bit
      for (int i = 0; i < 6; i++) begin
         idle <= i > 2;
         frame(i[0], i == 4);
      end
      summarize();
   end
   initial begin
      #900000;
      n_fail++;
      summarize();
   end
endmodule
`default_nettype wire
